/* File: src/irq_enable_bank_upper.sv */
// Purpose: Interrupt enable words 2 to 4 with per-source request gating
// Assumes: Classic Wishbone master; request flags held by an outer flag bank
// Notes: Ack comes one cycle after strobe; unmapped reads return zero and ack
`timescale 1ns/1ps

module irq_enable_bank_upper (
  input wire logic clk_sys,
  input wire logic rst,
  input wire irq_en_pkg::wb_req_s wb_req,
  output irq_en_pkg::wb_rsp_s wb_rsp,
  input wire logic timer6_irq,
  input wire logic dma_ch4_done_irq,
  input wire logic [3:0] out_cmp_irq,
  input wire logic [3:0] in_cap_irq,
  input wire logic dma_ch3_done_irq,
  input wire logic can_a_event_irq,
  input wire logic can_a_rx_ready_irq,
  input wire logic spi_b_event_irq,
  input wire logic spi_b_error_irq,
  input wire logic dma_ch5_done_irq,
  input wire logic can_b_event_irq,
  input wire logic can_b_rx_ready_irq,
  input wire logic ext_irq4,
  input wire logic ext_irq3,
  input wire logic timer9_irq,
  input wire logic timer8_irq,
  input wire logic i2c_b_master_irq,
  input wire logic i2c_b_slave_irq,
  input wire logic timer7_irq,
  input wire logic can_b_tx_request_irq,
  input wire logic can_a_tx_request_irq,
  input wire logic dma_ch7_done_irq,
  input wire logic dma_ch6_done_irq,
  input wire logic uart_b_error_irq,
  input wire logic uart_a_error_irq,
  output irq_en_pkg::irq_vec_s irq_enabled,
  output irq_en_pkg::irq_vec_s irq_gated,
  output logic irq_any
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } bus_state_e;

  bus_state_e state_q;
  bus_state_e state_d;
  logic [irq_en_pkg::BUS_W-1:0] rdata_q;
  logic [irq_en_pkg::BUS_W-1:0] rdata_d;
  logic req_valid;
  logic wr_fire;
  logic sel_w2;
  logic sel_w3;
  logic sel_w4;
  logic [1:0] lane;
  irq_en_pkg::irq_vec_s flags;
  irq_en_pkg::irq_vec_s en_all;
  irq_en_pkg::irq_vec_s gated_all;
  logic [irq_en_pkg::WORD_W-1:0] rd_word;

  // Pack request flags into the enable-word layout
  always_comb begin
    flags = '0;
    flags.word_2[irq_en_pkg::B2_TIMER6] = timer6_irq;
    flags.word_2[irq_en_pkg::B2_DMA4] = dma_ch4_done_irq;
    flags.word_2[irq_en_pkg::B2_OC8:irq_en_pkg::B2_OC5] = out_cmp_irq;
    flags.word_2[irq_en_pkg::B2_IC6:irq_en_pkg::B2_IC3] = in_cap_irq;
    flags.word_2[irq_en_pkg::B2_DMA3] = dma_ch3_done_irq;
    flags.word_2[irq_en_pkg::B2_CAN_A_EV] = can_a_event_irq;
    flags.word_2[irq_en_pkg::B2_CAN_A_RX] = can_a_rx_ready_irq;
    flags.word_2[irq_en_pkg::B2_SPI_B_EV] = spi_b_event_irq;
    flags.word_2[irq_en_pkg::B2_SPI_B_ERR] = spi_b_error_irq;
    flags.word_3[irq_en_pkg::B3_DMA5] = dma_ch5_done_irq;
    flags.word_3[irq_en_pkg::B3_CAN_B_EV] = can_b_event_irq;
    flags.word_3[irq_en_pkg::B3_CAN_B_RX] = can_b_rx_ready_irq;
    flags.word_3[irq_en_pkg::B3_EXT4] = ext_irq4;
    flags.word_3[irq_en_pkg::B3_EXT3] = ext_irq3;
    flags.word_3[irq_en_pkg::B3_TIMER9] = timer9_irq;
    flags.word_3[irq_en_pkg::B3_TIMER8] = timer8_irq;
    flags.word_3[irq_en_pkg::B3_TIMER7] = timer7_irq;
    flags.word_3[irq_en_pkg::B3_I2C_B_M] = i2c_b_master_irq;
    flags.word_3[irq_en_pkg::B3_I2C_B_S] = i2c_b_slave_irq;
    flags.word_4[irq_en_pkg::B4_CAN_B_TX] = can_b_tx_request_irq;
    flags.word_4[irq_en_pkg::B4_CAN_A_TX] = can_a_tx_request_irq;
    flags.word_4[irq_en_pkg::B4_DMA7] = dma_ch7_done_irq;
    flags.word_4[irq_en_pkg::B4_DMA6] = dma_ch6_done_irq;
    flags.word_4[irq_en_pkg::B4_UART_B_ERR] = uart_b_error_irq;
    flags.word_4[irq_en_pkg::B4_UART_A_ERR] = uart_a_error_irq;
  end

  // Address decode; the whole address is compared, so the low two address bits must be zero
  assign req_valid = wb_req.cyc && wb_req.stb;
  assign sel_w2 = wb_req.adr == irq_en_pkg::OFS_EN_WORD_2;
  assign sel_w3 = wb_req.adr == irq_en_pkg::OFS_EN_WORD_3;
  assign sel_w4 = wb_req.adr == irq_en_pkg::OFS_EN_WORD_4;
  // Write lands on the ack edge only, so a held request writes once
  assign wr_fire = req_valid && wb_req.we && (state_q == ST_ACK);
  assign lane = wr_fire ? wb_req.sel[1:0] : 2'b00;

  // Word 2: bit 13 unimplemented
  irq_en_word #(
    .IMPL_MASK(irq_en_pkg::MASK_EN_WORD_2)
  ) u_word_2 (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_lane(sel_w2 ? lane : 2'b00),
    .wr_data(wb_req.dat[irq_en_pkg::WORD_W-1:0]),
    .req_flags(flags.word_2),
    .en_value(en_all.word_2),
    .req_gated(gated_all.word_2)
  );

  // Word 3: bits 15-14 and 12-9 unimplemented
  irq_en_word #(
    .IMPL_MASK(irq_en_pkg::MASK_EN_WORD_3)
  ) u_word_3 (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_lane(sel_w3 ? lane : 2'b00),
    .wr_data(wb_req.dat[irq_en_pkg::WORD_W-1:0]),
    .req_flags(flags.word_3),
    .en_value(en_all.word_3),
    .req_gated(gated_all.word_3)
  );

  // Word 4: bits 15-8, 3 and 0 unimplemented
  irq_en_word #(
    .IMPL_MASK(irq_en_pkg::MASK_EN_WORD_4)
  ) u_word_4 (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_lane(sel_w4 ? lane : 2'b00),
    .wr_data(wb_req.dat[irq_en_pkg::WORD_W-1:0]),
    .req_flags(flags.word_4),
    .en_value(en_all.word_4),
    .req_gated(gated_all.word_4)
  );

  // Read mux; unmapped addresses read zero rather than erroring
  always_comb begin
    rd_word = '0;
    if (sel_w2) begin
      rd_word = en_all.word_2;
    end else if (sel_w3) begin
      rd_word = en_all.word_3;
    end else if (sel_w4) begin
      rd_word = en_all.word_4;
    end
  end

  // Bus handshake: one wait state, ack for exactly one cycle
  always_comb begin
    state_d = state_q;
    rdata_d = rdata_q;
    case (state_q)
      ST_IDLE: begin
        if (req_valid) begin
          state_d = ST_ACK;
          rdata_d = {{(irq_en_pkg::BUS_W - irq_en_pkg::WORD_W){1'b0}}, rd_word};
        end
      end
      ST_ACK: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Handshake state registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_IDLE;
      rdata_q <= '0;
    end else begin
      state_q <= state_d;
      rdata_q <= rdata_d;
    end
  end

  // Ack is combinational from state; data comes from a flop
  always_comb begin
    wb_rsp.ack = (state_q == ST_ACK) && req_valid;
    wb_rsp.dat = rdata_q;
  end

  assign irq_enabled = en_all;
  assign irq_gated = gated_all;
  assign irq_any = |gated_all;

endmodule // irq_enable_bank_upper

/* File: src/irq_en_pkg.sv */
// Purpose: Shared constants and carriers for the upper interrupt enable bank
// Assumes: Classic Wishbone slave, 32-bit data, three word-aligned registers
// Notes: Enable words are 16 bits wide; bits 31..16 read as zero
package irq_en_pkg;

  localparam int unsigned WORD_W = 16;
  localparam int unsigned NUM_WORDS = 3;
  localparam int unsigned BUS_W = 32;
  localparam int unsigned ADDR_W = 8;

  // Byte addresses of the enable words
  localparam logic [ADDR_W-1:0] OFS_EN_WORD_2 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EN_WORD_3 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EN_WORD_4 = 8'h08;

  // Implemented bit masks per word
  localparam logic [WORD_W-1:0] MASK_EN_WORD_2 = 16'hDFFF;
  localparam logic [WORD_W-1:0] MASK_EN_WORD_3 = 16'h21FF;
  localparam logic [WORD_W-1:0] MASK_EN_WORD_4 = 16'h00F6;

  // Power-on value of every enable bit
  localparam logic [WORD_W-1:0] RST_EN_WORD = 16'h0000;

  // Word 2 bit positions
  localparam int unsigned B2_TIMER6 = 15;
  localparam int unsigned B2_DMA4 = 14;
  localparam int unsigned B2_OC8 = 12;
  localparam int unsigned B2_OC5 = 9;
  localparam int unsigned B2_IC6 = 8;
  localparam int unsigned B2_IC3 = 5;
  localparam int unsigned B2_DMA3 = 4;
  localparam int unsigned B2_CAN_A_EV = 3;
  localparam int unsigned B2_CAN_A_RX = 2;
  localparam int unsigned B2_SPI_B_EV = 1;
  localparam int unsigned B2_SPI_B_ERR = 0;

  // Word 3 bit positions
  localparam int unsigned B3_DMA5 = 13;
  localparam int unsigned B3_CAN_B_EV = 8;
  localparam int unsigned B3_CAN_B_RX = 7;
  localparam int unsigned B3_EXT4 = 6;
  localparam int unsigned B3_EXT3 = 5;
  localparam int unsigned B3_TIMER9 = 4;
  localparam int unsigned B3_TIMER8 = 3;
  localparam int unsigned B3_I2C_B_M = 2;
  localparam int unsigned B3_I2C_B_S = 1;
  localparam int unsigned B3_TIMER7 = 0;

  // Word 4 bit positions
  localparam int unsigned B4_CAN_B_TX = 7;
  localparam int unsigned B4_CAN_A_TX = 6;
  localparam int unsigned B4_DMA7 = 5;
  localparam int unsigned B4_DMA6 = 4;
  localparam int unsigned B4_UART_B_ERR = 2;
  localparam int unsigned B4_UART_A_ERR = 1;

  // Source vectors in enable-word layout, one field per word
  typedef struct packed {
    logic [WORD_W-1:0] word_4;
    logic [WORD_W-1:0] word_3;
    logic [WORD_W-1:0] word_2;
  } irq_vec_s;

  // Wishbone request from master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADDR_W-1:0] adr;
    logic [BUS_W-1:0] dat;
  } wb_req_s;

  // Wishbone answer to master
  typedef struct packed {
    logic ack;
    logic [BUS_W-1:0] dat;
  } wb_rsp_s;

endpackage : irq_en_pkg

/* File: src/irq_en_word.sv */
// Purpose: One 16-bit enable word with fixed implemented-bit mask
// Assumes: Write strobe already qualified by address, ack and byte lanes
// Notes: Unimplemented positions never store and read zero
`timescale 1ns/1ps
module irq_en_word #(
  parameter logic [15:0] IMPL_MASK = 16'h0000
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] wr_lane,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] req_flags,
  output logic [15:0] en_value,
  output logic [15:0] req_gated
);

  logic [15:0] en_q;
  logic [15:0] en_d;

  // Lane-wise update; masked bits stay zero whatever is written
  always_comb begin
    en_d = en_q;
    if (wr_lane[0]) begin
      en_d[7:0] = wr_data[7:0] & IMPL_MASK[7:0];
    end
    if (wr_lane[1]) begin
      en_d[15:8] = wr_data[15:8] & IMPL_MASK[15:8];
    end
  end

  // Enables clear at reset so every source starts blocked
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      en_q <= irq_en_pkg::RST_EN_WORD;
    end else begin
      en_q <= en_d;
    end
  end

  assign en_value = en_q & IMPL_MASK;
  // Flags pass through untouched; only the forwarded copy is gated
  assign req_gated = req_flags & en_q & IMPL_MASK;

endmodule // irq_en_word

/* File: testbench/irq_bank_assertions.sv */
// Purpose: Bus timing and gating checks for the upper enable bank
// Assumes: Sees top-level ports only; one clock domain
// Notes: Bit layouts are written out here, not taken from the package
`timescale 1ns/1ps
module irq_bank_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire irq_en_pkg::wb_req_s wb_req,
  input wire irq_en_pkg::wb_rsp_s wb_rsp,
  input wire logic timer6_irq,
  input wire logic dma_ch5_done_irq,
  input wire irq_en_pkg::irq_vec_s irq_enabled,
  input wire irq_en_pkg::irq_vec_s irq_gated,
  input wire logic irq_any
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Fresh request answered next cycle, and the answer is a single pulse
  ack_latency_a: assert property ($rose(wb_req.cyc && wb_req.stb) |=> wb_rsp.ack)
    else $error("ack late");
  ack_pulse_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack stretched");
  // Full-lane write to word 2 lands masked at the ack edge
  write_apply_a: assert property (wb_rsp.ack && wb_req.we && wb_req.adr == 8'h00 &&
    wb_req.sel[1:0] == 2'h3 |=> irq_enabled.word_2 == ($past(wb_req.dat[15:0]) & 16'hDFFF))
    else $error("word 2 write lost");
  read_data_a: assert property (wb_rsp.ack && !wb_req.we && wb_req.adr == 8'h04
    |-> wb_rsp.dat == {16'h0000, irq_enabled.word_3}) else $error("word 3 read wrong");
  // Unimplemented positions never hold a one
  unimpl_zero_a: assert property ((irq_enabled.word_2 & 16'h2000) == 16'h0000 &&
    (irq_enabled.word_3 & 16'hDE00) == 16'h0000 && (irq_enabled.word_4 & 16'hFF09) == 16'h0000)
    else $error("unimplemented bit set");
  // Reset must win even though the default disable would mask it
  reset_clear_a: assert property (disable iff (1'b0) rst |=> irq_enabled == 48'h0)
    else $error("enables survive reset");
  gate_subset_a: assert property ((irq_gated & ~irq_enabled) == 48'h0)
    else $error("blocked request passed");
  any_or_a: assert property (irq_any == (|irq_gated))
    else $error("summary request wrong");
  timer6_gate_a: assert property (irq_gated.word_2[15] == (timer6_irq &&
    irq_enabled.word_2[15])) else $error("timer6 gating wrong");
  dma5_gate_a: assert property (irq_gated.word_3[13] == (dma_ch5_done_irq &&
    irq_enabled.word_3[13])) else $error("dma5 gating wrong");
endmodule // irq_bank_checker

bind irq_enable_bank_upper irq_bank_checker chk (.clk_sys, .rst, .wb_req, .wb_rsp,
  .timer6_irq, .dma_ch5_done_irq, .irq_enabled, .irq_gated, .irq_any);

/* File: testbench/irq_enable_bank_upper_tb_top.sv */
// Purpose: Self-checking bench for the upper enable bank
// Assumes: Classic Wishbone; the master waits up to 20 cycles for ack, then stops the run as failed
// Notes: Sources are one 48-bit vector laid out like the enable words
`timescale 1ns/1ps
module irq_enable_bank_upper_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  irq_en_pkg::wb_req_s wb_req = '0;
  irq_en_pkg::wb_rsp_s wb_rsp;
  irq_en_pkg::irq_vec_s irq_enabled;
  irq_en_pkg::irq_vec_s irq_gated;
  logic irq_any;
  logic [47:0] src = '0;
  logic [47:0] env;
  logic [15:0] en [3] = '{16'h0000, 16'h0000, 16'h0000};
  logic [15:0] msk [3] = '{16'hDFFF, 16'h21FF, 16'h00F6};
  logic [15:0] lane;
  logic [31:0] rd, dt, ex;
  logic [7:0] a;
  logic [3:0] s;
  logic we;
  int errors = 0;
  int checked = 0;
  assign env = {en[2], en[1], en[0]};
  // Source ports wired to their enable-word bit positions
  irq_enable_bank_upper dut (.clk_sys(clk_sys), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .timer6_irq(src[15]), .dma_ch4_done_irq(src[14]), .out_cmp_irq(src[12:9]),
    .in_cap_irq(src[8:5]), .dma_ch3_done_irq(src[4]), .can_a_event_irq(src[3]),
    .can_a_rx_ready_irq(src[2]), .spi_b_event_irq(src[1]), .spi_b_error_irq(src[0]),
    .dma_ch5_done_irq(src[29]), .can_b_event_irq(src[24]), .can_b_rx_ready_irq(src[23]),
    .ext_irq4(src[22]), .ext_irq3(src[21]), .timer9_irq(src[20]), .timer8_irq(src[19]),
    .i2c_b_master_irq(src[18]), .i2c_b_slave_irq(src[17]), .timer7_irq(src[16]),
    .can_b_tx_request_irq(src[39]), .can_a_tx_request_irq(src[38]),
    .dma_ch7_done_irq(src[37]), .dma_ch6_done_irq(src[36]), .uart_b_error_irq(src[34]),
    .uart_a_error_irq(src[33]), .irq_enabled(irq_enabled), .irq_gated(irq_gated),
    .irq_any(irq_any));
  // Free-running system clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // One classic cycle; ack and read data are taken at the rising edge, before it updates
  task automatic bus;
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: s, adr: a, dat: dt};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      report_and_stop();
    end
    rd = wb_rsp.dat;
    // Released right after the ack edge; the next call idles one cycle first
    wb_req <= '0;
  endtask
  // Reset reads, all-ones writes, then random traffic with random lanes and sources
  initial begin
    void'($urandom(32'h7f39324d));
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 60; i++) begin
      a = (i < 7) ? 8'((i % 4) * 4) : 8'(($urandom % 4) * 4);
      we = (i < 4) ? 1'b0 : (i < 7) ? 1'b1 : 1'($urandom);
      s = (i < 7) ? 4'hF : 4'($urandom);
      dt = (i < 7) ? 32'hFFFFFFFF : $urandom;
      ex = (a < 8'h0C) ? {16'h0000, en[a >> 2]} : 32'h00000000;
      bus();
      // New sources launched on the ack edge, settled by the mid-cycle checks
      src <= {16'($urandom), 32'($urandom)};
      if (!we) chk(48'(rd), 48'(ex));
      if (we && a < 8'h0C) begin
        lane = {{8{s[1]}}, {8{s[0]}}};
        en[a >> 2] = ((en[a >> 2] & ~lane) | (dt[15:0] & lane)) & msk[a >> 2];
      end
      @(negedge clk_sys);
      chk(irq_enabled, env);
      chk(irq_gated, src & env);
      chk(irq_gated, src & env);
      chk(48'(irq_any), 48'(|(src & env)));
    end
    // Second reset in mid-run clears every enable
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    en = '{16'h0000, 16'h0000, 16'h0000};
    @(negedge clk_sys);
    chk(irq_enabled, env);
    // Bus still answers after the mid-run reset, and word 2 reads back cleared
    a = 8'h00;
    we = 1'b0;
    s = 4'hF;
    bus();
    chk(48'(rd), 48'h000000000000);
    report_and_stop();
  end
  // Hang guard, far beyond the roughly 190 cycles the traffic needs
  initial begin
    #50000;
    errors++;
    report_and_stop();
  end
endmodule // irq_enable_bank_upper_tb_top
